// ===== logic/standard_event_group.sv
// Purpose: Standard event register, its enable mask and summary output.
// Assumes: Event set strobes come from logic on the same clock.
// Notes:   Set wins over clear-status in the same cycle.

`timescale 1ns/1ps

module standard_event_group
  import status_byte_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Control
  input  wire std_event_type stdIn,
  input  wire logic          clearStatus,
  // Results
  output logic [7:0]         eventReg,
  output logic [7:0]         eventMask,
  output logic               summary
);

  // ****************************************************************
  // Per-bit sticky event storage
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < EVENT_DEPTH; i++)
    begin : g_evt
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          eventReg[i] <= EVENT_RESET[i];
        else if (stdIn.setEvents[i])
          eventReg[i] <= 1'b1;
        else if (clearStatus)
          eventReg[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      eventMask <= ENABLE_RESET;
    else if (stdIn.eventMaskWrite)
      eventMask <= stdIn.eventMaskData;
  end

  wire logic next_summary;
  assign next_summary = |(eventReg & eventMask);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      summary <= 1'b0;
    else
      summary <= next_summary;
  end

endmodule : standard_event_group

// ===== logic/status_byte_pkg.sv
// Purpose: Constants and carrier types for the status byte and service
//          request block of a bus instrument.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bit positions are those of the status summary byte.

package status_byte_pkg;

  // ****************************************************************
  // Bit positions of the status summary byte
  // ****************************************************************
  localparam int ERROR_QUEUE_BIT   = 2;
  localparam int QUESTIONABLE_BIT  = 3;
  localparam int OUTPUT_QUEUE_BIT  = 4;
  localparam int STANDARD_EVT_BIT  = 5;
  localparam int REQUEST_SVC_BIT   = 6;
  localparam int OPERATION_BIT     = 7;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [7:0] ENABLE_RESET     = 8'h00;
  localparam logic [7:0] EVENT_RESET      = 8'h00;
  localparam logic [7:0] SUMMARY_MASK     = 8'hbf;
  localparam logic [7:0] ALWAYS_ZERO_MASK = 8'hfc;
  localparam int         EVENT_DEPTH      = 8;
  localparam logic [2:0] EVENT_LAST       = 3'h7;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Summary inputs from the lower status groups
  typedef struct packed {
    logic operation;
    logic questionable;
    logic outputReady;
    logic errorPending;
  } summary_type;

  // Commands from the instrument command parser, one-cycle strobes
  typedef struct packed {
    logic       serialPoll;
    logic       statusQuery;
    logic       enableWrite;
    logic       enableQuery;
    logic       clearStatus;
    logic [7:0] enableData;
  } command_type;

  // Standard event group inputs
  typedef struct packed {
    logic [7:0] setEvents;
    logic       eventMaskWrite;
    logic [7:0] eventMaskData;
  } std_event_type;

  typedef enum logic [1:0] {
    REQ_IDLE,
    REQ_PENDING
  } request_state_type;

endpackage : status_byte_pkg

// ===== logic/status_byte_service_request.sv
// Purpose: Status summary byte, service request enable and SRQ logic.
// Assumes: Command strobes come from the parser on the same clock; the
//          lower group summaries are synchronous except the SRQ pin side.
// Notes:   Outputs are registered, so answers appear one cycle after
//          the request strobe.

`timescale 1ns/1ps

module status_byte_service_request
  import status_byte_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Lower group summaries
  input  wire summary_type   summaryIn,
  input  wire std_event_type stdIn,
  // Commands
  input  wire command_type   cmdIn,
  // Bus service request line, open drain
  output logic               srqOut,
  output logic               srqOe,
  // Answers
  output logic [7:0]         pollByte,
  output logic               pollValid,
  output logic [7:0]         statusByte,
  output logic               statusValid,
  output logic [7:0]         enableByte,
  output logic               enableValid,
  output logic               errorQueueClear,
  output logic [7:0]         stdEventByte
);

  // ****************************************************************
  // Standard event group
  // ****************************************************************
  logic [7:0] stdEventReg;
  logic       stdSummary;

  standard_event_group u_std
  (
    .clk         (clk),
    .rst_b       (rst_b),
    .stdIn       (stdIn),
    .clearStatus (cmdIn.clearStatus),
    .eventReg    (stdEventReg),
    .eventMask   (),
    .summary     (stdSummary)
  );

  // ****************************************************************
  // Service request enable register
  // ****************************************************************
  logic [7:0] serviceRequestEnable;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      serviceRequestEnable <= ENABLE_RESET;
    else if (cmdIn.enableWrite)
      serviceRequestEnable <= cmdIn.enableData;
  end

  // ****************************************************************
  // Summary bits
  // ****************************************************************
  // Clear-status also masks the error queue summary for that cycle so
  // no stale error bit slips through while the queue is emptied.
  wire logic       errBit;
  wire logic [7:0] baseByte;
  assign errBit = summaryIn.errorPending & ~cmdIn.clearStatus;

  assign baseByte = {
    summaryIn.operation,
    1'b0,
    stdSummary,
    summaryIn.outputReady,
    summaryIn.questionable,
    errBit,
    2'b00
  } & ALWAYS_ZERO_MASK;

  wire logic [7:0] enabledReasons;
  wire logic       masterSummaryFlag;
  assign enabledReasons    = baseByte & serviceRequestEnable & SUMMARY_MASK;
  assign masterSummaryFlag = |enabledReasons;

  // ****************************************************************
  // Rising edge detect of enabled summaries
  // ****************************************************************
  logic [7:0] prevByte;

  // History keeps the raw error summary: the clear-cycle mask must not
  // look like a fresh rise while the queue is still draining
  wire logic [7:0] edgeByte;
  assign edgeByte = baseByte
                    | ({7'h00, summaryIn.errorPending} << ERROR_QUEUE_BIT);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prevByte <= EVENT_RESET;
    else
      prevByte <= edgeByte;
  end

  wire logic [7:0] risingEnabled;
  wire logic       startRequest;
  assign risingEnabled = baseByte & ~prevByte & serviceRequestEnable
                         & SUMMARY_MASK;

  // ****************************************************************
  // Request state
  // ****************************************************************
  request_state_type state;
  request_state_type next_state;

  assign startRequest = (state == REQ_IDLE) && (|risingEnabled);

  always_comb
  begin
    next_state = state;
    case (state)
      REQ_IDLE:
      begin
        if (startRequest)
          next_state = REQ_PENDING;
      end
      REQ_PENDING:
      begin
        if (cmdIn.serialPoll)
          next_state = REQ_IDLE;
      end
      default:
        next_state = REQ_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state <= REQ_IDLE;
    else
      state <= next_state;
  end

  // Request-service flag: bit 6 as seen by a serial poll
  wire logic requestServiceFlag;
  assign requestServiceFlag = (state == REQ_PENDING);

  wire logic [7:0] pollValue;
  wire logic [7:0] queryValue;
  assign pollValue  = baseByte
                      | ({7'h00, requestServiceFlag} << REQUEST_SVC_BIT);
  assign queryValue = baseByte
                      | ({7'h00, masterSummaryFlag} << REQUEST_SVC_BIT);

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      srqOut <= 1'b0;
      srqOe  <= 1'b0;
    end
    else
    begin
      // Open drain: pull low while the request is pending
      srqOut <= 1'b0;
      srqOe  <= (next_state == REQ_PENDING);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pollByte  <= EVENT_RESET;
      pollValid <= 1'b0;
    end
    else
    begin
      pollValid <= cmdIn.serialPoll;
      if (cmdIn.serialPoll)
        pollByte <= pollValue;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      statusByte  <= EVENT_RESET;
      statusValid <= 1'b0;
    end
    else
    begin
      statusValid <= cmdIn.statusQuery;
      if (cmdIn.statusQuery)
        statusByte <= queryValue;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      enableByte  <= ENABLE_RESET;
      enableValid <= 1'b0;
    end
    else
    begin
      enableValid <= cmdIn.enableQuery;
      if (cmdIn.enableQuery)
        enableByte <= serviceRequestEnable;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      errorQueueClear <= 1'b0;
      stdEventByte    <= EVENT_RESET;
    end
    else
    begin
      errorQueueClear <= cmdIn.clearStatus;
      stdEventByte    <= stdEventReg;
    end
  end

endmodule : status_byte_service_request

// ===== sim/poll_controller.sv
// Purpose: Bus controller model that serial polls on SRQ.
// Assumes: Poll strobe merged into the command bus.
// Notes:   WAIT sets the poll latency.
`timescale 1ns/1ps
module poll_controller
#(parameter int WAIT = 2)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus side
  input wire logic srqOe,
  input wire logic armed,
  output logic     pollReq
);
  int count;
  always_ff @(posedge clk)
    if (!rst_b || !armed || !srqOe || pollReq)
    begin
      count   <= 0;
      pollReq <= 1'b0;
    end
    else
    begin
      count   <= count + 1;
      pollReq <= (count == WAIT);
    end
endmodule : poll_controller

// ===== sim/status_byte_monitor.sv
// Purpose: Port checker for the status byte block.
// Assumes: Enable shadow follows write strobes.
// Notes:   Bound to the top module.
`timescale 1ns/1ps
module status_byte_monitor
  import status_byte_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Watched ports
  input wire summary_type summaryIn,
  input wire command_type cmdIn,
  input wire logic        srqOut,
  input wire logic        srqOe,
  input wire logic [7:0]  pollByte,
  input wire logic        pollValid,
  input wire logic [7:0]  statusByte,
  input wire logic        enableValid,
  input wire logic [7:0]  enableByte,
  input wire logic        errorQueueClear
);
  // ****
  // Checks
  // ****
  logic [7:0] shadow;
  always_ff @(posedge clk)
    if (!rst_b) shadow <= 8'h00;
    else if (cmdIn.enableWrite) shadow <= cmdIn.enableData;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_poll_answer: assert property
    (cmdIn.serialPoll |=> pollValid) else $error("poll unanswered");
  chk_flag_value: assert property
    (cmdIn.serialPoll |=> pollByte[6] == $past(srqOe)) else $error("flag");
  chk_poll_clears: assert property
    (cmdIn.serialPoll && srqOe |=> !srqOe) else $error("srq kept");
  chk_zero_bits: assert property
    (pollValid |-> pollByte[1:0] == 2'h0) else $error("low bits set");
  chk_group_bits: assert property
    (cmdIn.statusQuery && !cmdIn.clearStatus |=> statusByte[4:2] ==
     $past({summaryIn.outputReady, summaryIn.questionable,
            summaryIn.errorPending})) else $error("group bits");
  chk_master_sum: assert property
    (cmdIn.statusQuery && !cmdIn.enableWrite |=> statusByte[6] ==
     |(statusByte & shadow & SUMMARY_MASK)) else $error("summary");
  chk_query_keeps: assert property
    (cmdIn.statusQuery && srqOe && !cmdIn.serialPoll |=> srqOe)
    else $error("query cleared srq");
  chk_enable_read: assert property
    (cmdIn.enableQuery && !cmdIn.enableWrite |=> enableValid &&
     enableByte == shadow) else $error("enable read");
  chk_start_cause: assert property
    ($rose(srqOe) |-> ($past(shadow) & SUMMARY_MASK) != 8'h00)
    else $error("start unenabled");
  chk_clear_pulse: assert property
    (cmdIn.clearStatus |=> errorQueueClear) else $error("no clear");
  chk_open_drain: assert property
    (!srqOut) else $error("srq data high");
endmodule : status_byte_monitor
bind status_byte_service_request status_byte_monitor u_mon (.clk, .rst_b,
  .summaryIn, .cmdIn, .srqOut, .srqOe, .pollByte, .pollValid, .statusByte,
  .enableValid, .enableByte, .errorQueueClear);

// ===== sim/status_byte_service_request_test.sv
// Purpose: Self-checking bench for the status byte block.
// Assumes: 40 MHz clock, answers one cycle after strobes.
// Notes:   Poll model answers SRQ on its own.
`timescale 1ns/1ps
module status_byte_service_request_test;
  import status_byte_pkg::*;
  logic          clk, rst_b, armed, pollReq, stdOn;
  summary_type   sum;
  std_event_type std;
  command_type   cmd, cmdBus;
  logic          srqOut, srqOe, pollValid, statusValid, enableValid, eqc;
  logic [7:0]    pollByte, statusByte, enableByte, stdEventByte, en;
  int            mismatches, n_compared, cycles;
  // ****
  // Harness
  // ****
  always_comb
  begin
    cmdBus = cmd;
    cmdBus.serialPoll = cmd.serialPoll | pollReq;
  end
  status_byte_service_request DUT (.clk, .rst_b, .summaryIn(sum),
    .stdIn(std), .cmdIn(cmdBus), .srqOut, .srqOe, .pollByte, .pollValid,
    .statusByte, .statusValid, .enableByte, .enableValid,
    .errorQueueClear(eqc), .stdEventByte);
  poll_controller #(.WAIT(2)) ctrl (.clk, .rst_b, .srqOe, .armed, .pollReq);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check
  function automatic logic [7:0] expect_byte(input logic poll,
                                             input logic request_service_flag);
    logic [7:0] b;
    b = {sum.operation, 1'b0, stdOn, sum.outputReady, sum.questionable,
         sum.errorPending, 2'b00};
    b[REQUEST_SVC_BIT] = poll ? request_service_flag : |(b & en & SUMMARY_MASK);
    return b;
  endfunction : expect_byte
  task automatic ask(input logic [12:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask : ask
  task automatic query;
    ask(13'h0800);
    check({statusValid, statusByte}, {1'b1, expect_byte(1'b0, 1'b0)});
  endtask : query
  task automatic set_en(input logic [7:0] d);
    ask({5'b00100, d});
    en = d;
  endtask : set_en
  task automatic wait_poll;
    for (int k = 0; k < 20 && !pollValid; k++)
    begin
      @(posedge clk);
      #1;
    end
  endtask : wait_poll
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    ask(13'h0200);
    check({enableValid, enableByte}, 9'h100);
    query();
    $display("test reset done");
  endtask : t_reset
  task automatic t_bits;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) sum <= 4'h1 << i;
      query();
    end
    set_en(8'hfc);
    query();
    check({1'b0, srqOe}, 9'h0);
    ask(13'h0200);
    check({enableValid, enableByte}, 9'h1fc);
    $display("test bits done");
  endtask : t_bits
  task automatic t_srq;
    @(posedge clk) sum <= '0;
    set_en(8'h4c);
    armed <= 1'b1;
    @(posedge clk) sum <= 4'h1;
    @(posedge clk) sum <= 4'h5;
    #1;
    check({1'b0, srqOe}, 9'h1);
    wait_poll();
    check({pollValid, pollByte}, {1'b1, expect_byte(1'b1, 1'b1)});
    repeat (2) @(posedge clk);
    #1;
    check({1'b0, srqOe}, 9'h0);
    query();
    ask(13'h1000);
    check({pollValid, pollByte}, {1'b1, expect_byte(1'b1, 1'b0)});
    armed <= 1'b0;
    $display("test srq done");
  endtask : t_srq
  task automatic t_std;
    @(posedge clk) std <= {8'h00, 1'b1, 8'h01};
    @(posedge clk) std <= {8'h01, 1'b0, 8'h00};
    @(posedge clk) std <= '0;
    repeat (3) @(posedge clk);
    stdOn = 1'b1;
    query();
    check({1'b0, stdEventByte}, 9'h001);
    ask(13'h0100);
    check({1'b0, eqc}, 9'h1);
    stdOn = 1'b0;
    // Queue drains one cycle after the clear pulse, as hardware would
    @(posedge clk) sum <= 4'h4;
    repeat (2) @(posedge clk);
    #1;
    check({1'b0, srqOe}, 9'h0);
    query();
    $display("test std done");
  endtask : t_std
  initial
  begin
    rst_b = 1'b0;
    armed = 1'b0;
    stdOn = 1'b0;
    en = 8'h00;
    sum = '0;
    std = '0;
    cmd = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_bits();
    t_srq();
    t_std();
    end_of_test();
  end
endmodule : status_byte_service_request_test
